// file: core/dbm_dma_master.sv
`timescale 1ns/10ps
// One state step is one master-clock cycle; pin changes on half-clock
// phases are modelled at the nearest whole edge.
module dbm_dma_master #(
	parameter int ADDR_W = dbm_pkg::DBM_ADDR_W,
	parameter int DATA_W = dbm_pkg::DBM_DATA_W
) (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_nrst,
	// Configuration
	input  wire logic                     i_word_mode,
	input  wire logic [1:0]               i_programmed_wait,
	input  wire logic                     i_ack_check_en,
	// Channel requests, index = {serial channel, transmit}
	input  wire logic [3:0]               i_chan_req,
	input  wire dbm_pkg::dbm_req_s [3:0]  i_chan_info,
	output logic [3:0]                    o_chan_done,
	output logic [DATA_W-1:0]             o_rd_data,
	output logic                          o_rd_byte_only,
	// Bus pins in
	input  wire logic                     i_transfer_ack_n,
	input  wire logic                     i_bus_error_in_n,
	input  wire logic                     i_bus_grant_in_n,
	input  wire logic                     i_grant_acknowledge_n,
	input  wire logic                     i_address_strobe_n,
	input  wire logic                     i_chip_select_n,
	input  wire logic                     i_interrupt_ack_in_n,
	input  wire logic [DATA_W-1:0]        i_data,
	// Bus pins out
	output logic                          o_bus_request_out_n,
	output dbm_pkg::dbm_bus_s             o_bus,
	// Error events to the channels
	output logic [1:0]                    o_clr_receiver_enable_bit,
	output logic [1:0]                    o_clr_tx_dma_permit_bit,
	output logic                          o_bus_error_irq,
	output logic                          o_address_error_irq
);
	import dbm_pkg::*;

	dbm_state_e            st_q, st_d;
	dbm_chan_t             ch_q, ch_d, poll_q, poll_d;
	dbm_req_s              req_q, req_d;
	dbm_bus_s              bus_q, bus_d;
	logic [1:0]            good_q, good_d;
	logic [1:0]            gap_q, gap_d;
	logic                  bus_error_in_q, bus_error_in_d;
	logic                  aerr_q, aerr_d;
	logic [3:0]            done_d;
	logic [1:0]            rxclr_d, txclr_d;
	logic                  beirq_d, aeirq_d;
	logic [DATA_W-1:0]     rdat_q, rdat_d;
	logic                  rbyte_q, rbyte_d;
	logic                  breq_q, breq_d;
	logic                  wstart, wstep, wdone;
	logic                  is_read, arb_ok, ack_ok;

	dbm_wait_gen u_wait (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_start(wstart),
		.i_step (wstep),
		.i_sel  (i_programmed_wait),
		.o_done (wdone)
	);

	assign is_read = ch_q[0];
	assign arb_ok  = !i_bus_grant_in_n && i_grant_acknowledge_n && i_address_strobe_n;
	assign ack_ok  = !i_ack_check_en || !i_transfer_ack_n;
	assign wstart  = (st_q == DBM_S0);
	assign wstep   = (st_q == DBM_S2);

	always_comb begin
		st_d    = st_q;
		ch_d    = ch_q;
		poll_d  = poll_q;
		req_d   = req_q;
		bus_d   = bus_q;
		good_d  = good_q;
		gap_d   = gap_q;
		bus_error_in_d  = bus_error_in_q;
		aerr_d  = aerr_q;
		rdat_d  = rdat_q;
		rbyte_d = rbyte_q;
		breq_d  = breq_q;
		done_d  = 4'h0;
		rxclr_d = 2'h0;
		txclr_d = 2'h0;
		beirq_d = 1'b0;
		aeirq_d = 1'b0;
		unique case (st_q)
			DBM_IDLE: begin
				if (i_chan_req[poll_q]) begin
					ch_d   = poll_q;
					req_d  = i_chan_info[poll_q];
					breq_d = 1'b1;
					good_d = 2'h0;
					st_d   = DBM_REQ;
				end
				poll_d = poll_q + 2'h1;
			end
			DBM_REQ: begin
				good_d = arb_ok ? ((good_q == 2'(DBM_ARB_SAMPLES - 1)) ? good_q : good_q + 2'h1) : 2'h0;
				if (arb_ok && good_q == 2'(DBM_ARB_SAMPLES - 1)) begin
					breq_d                     = 1'b0;
					bus_d.grant_acknowledge_n  = 1'b0;
					bus_d.ctrl_oe              = 1'b1;
					bus_d.holder_oe              = 1'b1;
					bus_d.channel_bus_holder_0_n = ch_q[1];
					bus_d.channel_bus_holder_1_n = !ch_q[1];
					bus_d.rnw     = is_read;
					bus_d.addr_oe = 1'b1;
					// full 16-bit address incl. bit zero in byte mode
					bus_d.addr    = i_word_mode ? {req_q.addr[ADDR_W-1:1], 1'b0} : req_q.addr;
					// byte mode: upper strobe pin is address bit zero
					bus_d.upper_data_strobe_n = i_word_mode ? 1'b1 : req_q.addr[0];
					st_d          = DBM_OWN;
				end
			end
			DBM_OWN: begin
				bus_d.address_strobe_n = 1'b0;
				if (is_read) begin
					// bit zero must not glitch low in byte mode
					bus_d.upper_data_strobe_n = i_word_mode ? 1'b0 : req_q.addr[0];
					bus_d.lower_data_strobe_n = 1'b0;
				end else begin
					// odd tail still a full word
					bus_d.data    = req_q.wdata;
					bus_d.data_oe = 1'b1;
				end
				st_d = DBM_S0;
			end
			DBM_S0: begin
				// write data strobes one edge later (reads drove them with the address strobe); byte mode: lower is the strobe, upper is bit zero
				bus_d.lower_data_strobe_n = 1'b0;
				bus_d.upper_data_strobe_n = i_word_mode ? 1'b0 : req_q.addr[0];
				st_d = DBM_S2;
			end
			DBM_S2: begin
				if (wdone) begin
					st_d = DBM_S4;
				end
			end
			DBM_S4: begin
				if (!i_chip_select_n || !i_interrupt_ack_in_n) begin
					aerr_d = 1'b1;
				end
				if (!i_bus_error_in_n) begin
					st_d = DBM_QUAL;
				end else if (ack_ok) begin
					bus_d.address_strobe_n    = 1'b1;
					bus_d.upper_data_strobe_n = 1'b1;
					bus_d.lower_data_strobe_n = 1'b1;
					if (is_read) begin
						rdat_d  = i_data;
						rbyte_d = req_q.odd_tail;
					end
					done_d[ch_q] = 1'b1;
					st_d         = DBM_PULL;
				end
			end
			DBM_QUAL: begin
				if (!i_bus_error_in_n) begin
					bus_error_in_d = 1'b1;
					bus_d.address_strobe_n    = 1'b1;
					bus_d.upper_data_strobe_n = 1'b1;
					bus_d.lower_data_strobe_n = 1'b1;
					st_d = DBM_PULL;
				end else begin
					st_d = DBM_S4;
				end
			end
			DBM_PULL: begin
				bus_d.addr_oe                = 1'b0;
				bus_d.data_oe                = 1'b0;
				bus_d.grant_acknowledge_n    = 1'b1;
				bus_d.channel_bus_holder_0_n = 1'b1;
				bus_d.channel_bus_holder_1_n = 1'b1;
				bus_d.rnw                    = 1'b1;
				if (!bus_q.grant_acknowledge_n) begin
					st_d = DBM_PULL;
				end else begin
					bus_d.ctrl_oe   = 1'b0;
					bus_d.holder_oe = 1'b0;
					if (bus_error_in_q) begin
						if (is_read) begin
							txclr_d[ch_q[1]] = 1'b1;
						end else begin
							rxclr_d[ch_q[1]] = 1'b1;
						end
						beirq_d = 1'b1;
					end
					aeirq_d = aerr_q;
					bus_error_in_d  = 1'b0;
					aerr_d  = 1'b0;
					gap_d   = 2'(DBM_REREQ_GAP_CYC - 1);
					st_d    = DBM_GAP;
				end
			end
			DBM_GAP: begin
				if (gap_q == 2'h0) begin
					st_d = DBM_IDLE;
				end else begin
					gap_d = gap_q - 2'h1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			st_q    <= DBM_IDLE;
			ch_q    <= 2'h0;
			poll_q  <= 2'h0;
			req_q   <= '0;
			bus_q   <= '{addr: '0, addr_oe: 1'b0, data: '0, data_oe: 1'b0, rnw: 1'b1,
			             address_strobe_n: 1'b1, upper_data_strobe_n: 1'b1, lower_data_strobe_n: 1'b1,
			             grant_acknowledge_n: 1'b1, ctrl_oe: 1'b0, channel_bus_holder_0_n: 1'b1,
			             channel_bus_holder_1_n: 1'b1, holder_oe: 1'b0};
			good_q  <= 2'h0;
			gap_q   <= 2'h0;
			bus_error_in_q  <= 1'b0;
			aerr_q  <= 1'b0;
			rdat_q  <= '0;
			rbyte_q <= 1'b0;
			breq_q  <= 1'b0;
			o_chan_done               <= 4'h0;
			o_clr_receiver_enable_bit <= 2'h0;
			o_clr_tx_dma_permit_bit   <= 2'h0;
			o_bus_error_irq           <= 1'b0;
			o_address_error_irq       <= 1'b0;
		end else begin
			st_q    <= st_d;
			ch_q    <= ch_d;
			poll_q  <= poll_d;
			req_q   <= req_d;
			bus_q   <= bus_d;
			good_q  <= good_d;
			gap_q   <= gap_d;
			bus_error_in_q  <= bus_error_in_d;
			aerr_q  <= aerr_d;
			rdat_q  <= rdat_d;
			rbyte_q <= rbyte_d;
			breq_q  <= breq_d;
			o_chan_done               <= done_d;
			o_clr_receiver_enable_bit <= rxclr_d;
			o_clr_tx_dma_permit_bit   <= txclr_d;
			o_bus_error_irq           <= beirq_d;
			o_address_error_irq       <= aeirq_d;
		end
	end

	assign o_bus               = bus_q;
	assign o_bus_request_out_n = !breq_q;
	assign o_rd_data           = rdat_q;
	assign o_rd_byte_only      = rbyte_q;

	// Assertions
	// holders
	a_holder_exclusive: assert property (@(posedge i_clk) disable iff (!i_nrst)
		!o_bus.grant_acknowledge_n |-> (o_bus.channel_bus_holder_0_n != o_bus.channel_bus_holder_1_n) && o_bus.holder_oe)
		else $error("holder pins not exclusive");
	a_gap_no_request: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_bus.grant_acknowledge_n) |-> o_bus_request_out_n [*3])
		else $error("bus re-requested too soon");
	a_request_drop: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_bus.grant_acknowledge_n) |-> o_bus_request_out_n)
		else $error("request still asserted with grant ack");
	a_arb_two_samples: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_bus.grant_acknowledge_n) |-> $past(arb_ok) && $past(arb_ok, 2))
		else $error("ownership without two good samples");
	a_strobe_order: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_bus.address_strobe_n) && !o_bus.rnw |=> !o_bus.lower_data_strobe_n && o_bus.data_oe)
		else $error("write data strobe not one edge after address strobe");
	a_zero_wait_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_bus.address_strobe_n) && !o_bus.rnw && i_programmed_wait == DBM_WAIT_0
		|-> !o_bus.address_strobe_n [*3] ##1
		(o_bus.address_strobe_n || !$past(ack_ok) || !$past(i_bus_error_in_n)))
		else $error("zero-wait write not three cycles long");
	a_end_negates: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_bus.grant_acknowledge_n) |-> o_bus.channel_bus_holder_0_n && o_bus.channel_bus_holder_1_n)
		else $error("holders not negated at cycle end");
	a_pullup_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$fell(o_bus.ctrl_oe) |-> $past(o_bus.ctrl_oe) && $past(o_bus.address_strobe_n) && $past(o_bus.grant_acknowledge_n))
		else $error("controls floated without pull-high");
	a_bus_error_in_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == DBM_QUAL && !i_bus_error_in_n && !is_read) |-> ##[1:4] (o_clr_receiver_enable_bit != 2'h0))
		else $error("receiver enable not cleared on bus error");
	a_bus_error_in_permit: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == DBM_QUAL && !i_bus_error_in_n && is_read) |-> ##[1:4] (o_clr_tx_dma_permit_bit != 2'h0))
		else $error("transmit permit not cleared on bus error");
	a_addr_error: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(st_q == DBM_S4 && (!i_chip_select_n || !i_interrupt_ack_in_n)) |-> ##[1:4] o_address_error_irq)
		else $error("address error not raised");
	c_write_done: cover property (@(posedge i_clk) disable iff (!i_nrst) st_q == DBM_S4 && !is_read && ack_ok);
	c_read_done: cover property (@(posedge i_clk) disable iff (!i_nrst) st_q == DBM_S4 && is_read && ack_ok);
	c_bus_error: cover property (@(posedge i_clk) disable iff (!i_nrst) o_bus_error_irq);

endmodule // dbm_dma_master

// file: core/dbm_pkg.sv
package dbm_pkg;

	// Bus-side widths and counts
	localparam int DBM_ADDR_W = 16;
	localparam int DBM_DATA_W = 16;
	localparam int DBM_NCHAN  = 4;

	// Least gap after release, in master clock cycles
	localparam int DBM_REREQ_GAP_CYC = 3;
	// Successive good arbitration samples needed
	localparam int DBM_ARB_SAMPLES = 2;
	// Clock-phase pull-up length before float
	localparam int DBM_PULLUP_CYC = 1;

	// Wait-state selection codes
	localparam logic [1:0] DBM_WAIT_0 = 2'h0;
	localparam logic [1:0] DBM_WAIT_1 = 2'h1;
	localparam logic [1:0] DBM_WAIT_2 = 2'h2;
	localparam logic [1:0] DBM_WAIT_4 = 2'h3;

	// Channel index: bit0 = direction (1 = transmit/read), bit1 = serial channel
	typedef logic [1:0] dbm_chan_t;

	typedef struct packed {
		logic [DBM_ADDR_W-1:0] addr;
		logic [DBM_DATA_W-1:0] wdata;
		logic                  odd_tail;
	} dbm_req_s;

	// Bus pin drive bundle: value per pin, output enable per pin group
	typedef struct packed {
		logic [DBM_ADDR_W-1:0] addr;
		logic                  addr_oe;
		logic [DBM_DATA_W-1:0] data;
		logic                  data_oe;
		logic                  rnw;
		logic                  address_strobe_n;
		logic                  upper_data_strobe_n;
		logic                  lower_data_strobe_n;
		logic                  grant_acknowledge_n;
		logic                  ctrl_oe;
		logic                  channel_bus_holder_0_n;
		logic                  channel_bus_holder_1_n;
		logic                  holder_oe;
	} dbm_bus_s;

	typedef enum {
		DBM_IDLE,
		DBM_REQ,
		DBM_OWN,
		DBM_S0,
		DBM_S2,
		DBM_S4,
		DBM_QUAL,
		DBM_PULL,
		DBM_GAP
	} dbm_state_e;

endpackage

// file: core/dbm_wait_gen.sv
`timescale 1ns/10ps
// Counts programmed wait states; done is held high while the count is zero
module dbm_wait_gen (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// Control
	input  wire logic       i_start,
	input  wire logic       i_step,
	input  wire logic [1:0] i_sel,
	// Status
	output logic            o_done
);
	import dbm_pkg::*;

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [2:0] load_v;

	always_comb begin
		unique case (i_sel)
			DBM_WAIT_0: load_v = 3'h0;
			DBM_WAIT_1: load_v = 3'h1;
			DBM_WAIT_2: load_v = 3'h2;
			DBM_WAIT_4: load_v = 3'h4;
		endcase
	end

	always_comb begin
		cnt_d = cnt_q;
		if (i_start) begin
			cnt_d = load_v;
		end else if (i_step && cnt_q != 3'h0) begin
			cnt_d = cnt_q - 3'h1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign o_done = (cnt_q == 3'h0);

endmodule // dbm_wait_gen

// file: testbench/dbm_bus_partner.sv
`timescale 1ns/10ps
// Arbiter and memory on the far side of the bus
module dbm_bus_partner
	import dbm_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	// From the master
	input  wire logic        i_bus_request_out_n,
	input  wire dbm_bus_s    i_bus,
	// Test controls
	input  wire logic [3:0]  i_ack_dly,
	input  wire logic        i_ack_off,
	input  wire logic        i_bus_error_in_on,
	// Bus levels back to the master
	output logic             o_bus_grant_in_n,
	output logic             o_transfer_ack_n,
	output logic             o_bus_error_in_n,
	output logic             o_address_strobe_n,
	output logic             o_grant_acknowledge_n,
	output logic [15:0]      o_data
);
	logic [3:0]  as_cnt_q;
	logic [15:0] last_q;
	logic        as_on;
	// Pull-ups hold released control lines high
	assign o_address_strobe_n    = i_bus.ctrl_oe ? i_bus.address_strobe_n : 1'b1;
	assign o_grant_acknowledge_n = i_bus.ctrl_oe ? i_bus.grant_acknowledge_n : 1'b1;
	assign as_on = !o_address_strobe_n;
	// Released data toggles so a stale value never passes
	assign o_data = i_bus.data_oe ? i_bus.data : (as_on && i_bus.rnw) ? (i_bus.addr ^ 16'h5a3c) : ~last_q;
	// Slow memory answers after i_ack_dly strobe cycles
	assign o_transfer_ack_n = !(as_on && !i_ack_off && !i_bus_error_in_on && as_cnt_q >= i_ack_dly);
	assign o_bus_error_in_n = !(as_on && i_bus_error_in_on);
	always_ff @(posedge i_clk) begin
		last_q <= o_data;
		as_cnt_q <= (!i_nrst || !as_on) ? 4'h0 : as_cnt_q + {3'h0, as_cnt_q != 4'hf};
		o_bus_grant_in_n <= !i_nrst || i_bus_request_out_n;
	end
endmodule // dbm_bus_partner

// file: testbench/tb_dma_bus_master_arbitration.sv
`timescale 1ns/10ps
module tb_dma_bus_master_arbitration;
	import dbm_pkg::*;
	logic i_clk = 1'b0, i_nrst = 1'b0, word = 1'b1, ack_en = 1'b1, cs_n = 1'b1, interrupt_ack_in_n = 1'b1;
	logic ack_off = 1'b0, bus_error_in_on = 1'b0, req_n, bg_n, ta_n, be_n, as_n, ga_n, byte_only, bus_error_in_irq, aerr_irq;
	logic [1:0] pw = 2'h0, clr_rx, clr_tx, rx_seen, tx_seen;
	logic [3:0] req = 4'h0, dly = 4'h0, done, done_seen;
	logic [15:0] rd, din;
	logic be_seen, ae_seen, prev_req_n;
	dbm_req_s [3:0] info = '0;
	dbm_bus_s bus, snap, prev;
	int n_errors = 0, checks_done = 0, cyc = 0, as_cyc, as_falls, rel = 1000, gap_min, pull_bad;
	always #5 i_clk = ~i_clk;
	dbm_dma_master dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_word_mode(word), .i_programmed_wait(pw),
		.i_ack_check_en(ack_en), .i_chan_req(req), .i_chan_info(info), .o_chan_done(done), .o_rd_data(rd),
		.o_rd_byte_only(byte_only), .i_transfer_ack_n(ta_n), .i_bus_error_in_n(be_n), .i_bus_grant_in_n(bg_n),
		.i_grant_acknowledge_n(ga_n), .i_address_strobe_n(as_n), .i_chip_select_n(cs_n),
		.i_interrupt_ack_in_n(interrupt_ack_in_n), .i_data(din), .o_bus_request_out_n(req_n), .o_bus(bus),
		.o_clr_receiver_enable_bit(clr_rx), .o_clr_tx_dma_permit_bit(clr_tx), .o_bus_error_irq(bus_error_in_irq),
		.o_address_error_irq(aerr_irq));
	dbm_bus_partner far (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus_request_out_n(req_n), .i_bus(bus),
		.i_ack_dly(dly), .i_ack_off(ack_off), .i_bus_error_in_on(bus_error_in_on), .o_bus_grant_in_n(bg_n),
		.o_transfer_ack_n(ta_n), .o_bus_error_in_n(be_n), .o_address_strobe_n(as_n),
		.o_grant_acknowledge_n(ga_n), .o_data(din));
	// Settled view of the bus, half a cycle after each edge
	always @(negedge i_clk) begin
		if (!as_n) as_cyc++;
		if (!as_n && prev.address_strobe_n) as_falls++;
		if (!as_n && !bus.lower_data_strobe_n) snap = bus;
		if (prev.ctrl_oe && !bus.ctrl_oe && (prev.address_strobe_n !== 1'b1 || prev.grant_acknowledge_n !== 1'b1))
			pull_bad++;
		rel = (prev.ctrl_oe && !bus.ctrl_oe) ? 0 : rel + 1;
		if (prev_req_n && !req_n && rel < gap_min) gap_min = rel;
		done_seen |= done;
		rx_seen |= clr_rx;
		tx_seen |= clr_tx;
		be_seen |= bus_error_in_irq;
		ae_seen |= aerr_irq;
		prev = bus;
		prev_req_n = req_n;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Requests the indices in m and waits for completion or error
	task automatic run_xfer(input logic [3:0] m, input logic [15:0] a, input logic odd);
		int n;
		@(posedge i_clk);
		as_cyc = 0;
		as_falls = 0;
		pull_bad = 0;
		gap_min = 1000;
		snap = '0;
		{done_seen, rx_seen, tx_seen, be_seen, ae_seen} = '0;
		for (int i = 0; i < 4; i++)
			info[i] <= '{addr: a, wdata: ~a, odd_tail: odd};
		req <= m;
		n = 0;
		while ((done_seen & m) != m && !be_seen && !ae_seen && n < 300) begin
			@(posedge i_clk);
			n++;
		end
		req <= 4'h0;
		repeat (12) @(posedge i_clk);
		chk(n < 300, 1);
	endtask
	task automatic sc_write_word;
		word <= 1'b1;
		run_xfer(4'h4, 16'hfffe, 1'b0);
		chk(as_cyc, 3);
		chk(as_falls, 1);
		chk(snap.addr, 16'hfffe);
		chk({snap.data_oe, snap.data}, {1'b1, 16'h0001});
		chk({snap.rnw, snap.upper_data_strobe_n}, 2'h0);
		chk({snap.channel_bus_holder_1_n, snap.channel_bus_holder_0_n, snap.holder_oe}, 3'h3);
		chk({snap.grant_acknowledge_n, snap.ctrl_oe}, 2'h1);
		chk(pull_bad, 0);
		chk({bus.ctrl_oe, bus.holder_oe, bus.addr_oe}, 3'h0);
	endtask
	task automatic sc_reads;
		word <= 1'b0;
		run_xfer(4'h2, 16'h1235, 1'b0);
		chk({snap.addr, snap.upper_data_strobe_n, snap.rnw}, {16'h1235, 2'h3});
		chk(rd[7:0], 8'h09);
		word <= 1'b1;
		run_xfer(4'h8, 16'h0040, 1'b1);
		chk({rd, byte_only}, {16'h5a7c, 1'b1});
		chk({snap.upper_data_strobe_n, snap.channel_bus_holder_0_n}, 2'h1);
	endtask
	task automatic sc_waits;
		for (int c = 0; c < 4; c++) begin
			pw <= 2'(c);
			run_xfer(4'h1 << c, 16'h0100, 1'b0);
			chk(as_cyc, (c == 3) ? 7 : 3 + c);
			chk(done_seen, 4'h1 << c);
		end
		pw <= 2'h0;
	endtask
	task automatic sc_ack;
		dly <= 4'h6;
		run_xfer(4'h1, 16'h0200, 1'b0);
		chk(as_cyc, 7);
		dly <= 4'h0;
		{ack_off, ack_en, pw} <= 4'h9;
		run_xfer(4'h2, 16'h0202, 1'b0);
		chk(as_cyc, 4);
		{ack_off, ack_en, pw} <= 4'h4;
	endtask
	task automatic sc_back2back;
		run_xfer(4'h5, 16'h0300, 1'b0);
		chk(done_seen, 4'h5);
		chk(as_falls, 2);
		chk(gap_min >= 3, 1);
		chk(snap.addr_oe && bus.addr_oe === 1'b0, 1);
	endtask
	task automatic sc_errors;
		bus_error_in_on <= 1'b1;
		run_xfer(4'h1, 16'h0400, 1'b0);
		repeat (4) @(posedge i_clk);
		chk({be_seen, rx_seen, tx_seen}, 5'h14);
		run_xfer(4'h8, 16'h0402, 1'b0);
		repeat (4) @(posedge i_clk);
		chk({be_seen, rx_seen, tx_seen}, 5'h12);
		bus_error_in_on <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			{cs_n, interrupt_ack_in_n} <= k ? 2'h2 : 2'h1;
			run_xfer(4'h2, 16'h0500, 1'b0);
			repeat (4) @(posedge i_clk);
			chk(ae_seen, 1);
		end
		{cs_n, interrupt_ack_in_n} <= 2'h3;
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop;
		end
	end
	initial begin
		repeat (16) @(posedge i_clk);
		i_nrst <= 1'b1;
		sc_write_word;
		sc_reads;
		sc_waits;
		sc_ack;
		sc_back2back;
		sc_errors;
		report_and_stop;
	end
endmodule // tb_dma_bus_master_arbitration
